// ===== spio_regs.svh
// Port numbers, field positions and timing counts for the I/O port block.
`ifndef SPIO_REGS_SVH
`define SPIO_REGS_SVH
// ----------------------------------------------------------------
// Port numbers
// ----------------------------------------------------------------
`define SPIO_SERIAL_DATA_PORT 8'hFC
`define SPIO_SERIAL_STATUS_CONFIG 8'hFD
`define SPIO_CONTROL_HANDSHAKE_PORT 8'hFE
`define SPIO_PARALLEL_DATA_PORT 8'hFF
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPIO_ST_TX_EMPTY 0
`define SPIO_ST_RX_AVAIL 1
`define SPIO_ST_OVERRUN 2
`define SPIO_ST_FRAMING 3
`define SPIO_ST_PARITY 4
`define SPIO_CF_STOP2 2
`define SPIO_CF_PAR_ODD_N 3
`define SPIO_CF_NO_PARITY 4
`define SPIO_CT_MOTOR1 4
`define SPIO_CT_MOTOR2 5
`define SPIO_CT_RATE 6
`define SPIO_CT_SERIAL_SEL 7
`define SPIO_HS_AVAIL 6
`define SPIO_HS_ACK 7
// ----------------------------------------------------------------
// Reset values, timing and ROM base
// ----------------------------------------------------------------
`define SPIO_FMT_RESET 8'h00
`define SPIO_CTRL_RESET 8'h00
`define SPIO_CLK_HZ 50000000
`define SPIO_BAUD_LO 300
`define SPIO_BAUD_HI 1200
`define SPIO_BIT_CYC_LO (`SPIO_CLK_HZ / `SPIO_BAUD_LO)
`define SPIO_BIT_CYC_HI (`SPIO_CLK_HZ / `SPIO_BAUD_HI)
`define SPIO_ROM_BASE 16'hE000
`endif

// ===== spio_pkg.sv
// Types shared by the I/O port block.
package spio_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} spio_io_req_t;
	typedef enum logic [1:0] {
		SPIO_IDLE = 2'b00,
		SPIO_DATA = 2'b01,
		SPIO_PAR = 2'b10,
		SPIO_STOP = 2'b11
	} spio_st_t;
endpackage

// ===== spio_fifo.sv
// Small synchronous FIFO for the transmit path.
`timescale 1ns/10ps
module spio_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q, wp_d, rp_q, rp_d;
	logic push, pop;
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wp_q[AW-1:0]] <= in_data;
		end
	end
	assign in_ready = !((wp_q[AW] != rp_q[AW]) &&
		(wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign out_valid = (wp_q != rp_q);
	assign out_data = mem_q[rp_q[AW-1:0]];
endmodule

// ===== spio_ports.sv
// Processor I/O ports: serial/cassette channel, parallel port, controls.
`timescale 1ns/10ps
`include "spio_regs.svh"
module spio_ports #(
	parameter int CLK_HZ = `SPIO_CLK_HZ
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Processor I/O bus
	input wire spio_pkg::spio_io_req_t io_req,
	output logic [7:0] io_rdata,
	// Memory decode
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic rom_sel,
	output logic [15:0] rom_addr,
	// Serial and cassette lines
	input wire logic serial_rx,
	input wire logic cass_rx,
	output logic serial_tx,
	output logic cass_tx,
	// Tape motors
	output logic motor1_on,
	output logic motor2_on,
	// Parallel port
	input wire logic [7:0] par_in,
	input wire logic par_avail,
	output logic [7:0] par_out,
	output logic par_ack
);
	import spio_pkg::*;

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	logic [1:0] srx_q, crx_q, pav_q;
	logic [7:0] pin1_q, pin2_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			srx_q <= 2'b11;
			crx_q <= 2'b11;
			pav_q <= 2'b00;
			pin1_q <= 8'h00;
			pin2_q <= 8'h00;
		end else begin
			srx_q <= {srx_q[0], serial_rx};
			crx_q <= {crx_q[0], cass_rx};
			pav_q <= {pav_q[0], par_avail};
			pin1_q <= par_in;
			pin2_q <= pin1_q;
		end
	end

	// ----------------------------------------------------------------
	// Port registers
	// ----------------------------------------------------------------
	logic [7:0] fmt_q, fmt_d, ctrl_q, ctrl_d, pout_q, pout_d;
	logic ack_q, ack_d, boot_q, boot_d;
	logic wr_fc, wr_fd, wr_fe, wr_ff, rd_fc;
	always_comb begin
		wr_fc = io_req.wr && io_req.addr == `SPIO_SERIAL_DATA_PORT;
		wr_fd = io_req.wr && io_req.addr == `SPIO_SERIAL_STATUS_CONFIG;
		wr_fe = io_req.wr && io_req.addr == `SPIO_CONTROL_HANDSHAKE_PORT;
		wr_ff = io_req.wr && io_req.addr == `SPIO_PARALLEL_DATA_PORT;
		rd_fc = io_req.rd && io_req.addr == `SPIO_SERIAL_DATA_PORT;
		fmt_d = wr_fd ? io_req.wdata : fmt_q;
		ctrl_d = wr_fe ? io_req.wdata : ctrl_q;
		pout_d = wr_ff ? io_req.wdata : pout_q;
		ack_d = wr_fe ? io_req.wdata[`SPIO_HS_ACK] : ack_q;
		// map ROM until first fetch above it
		boot_d = boot_q && !(mem_rd && mem_addr[15:13] == 3'b111);
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fmt_q <= `SPIO_FMT_RESET;
			ctrl_q <= `SPIO_CTRL_RESET;
			pout_q <= 8'h00;
			ack_q <= 1'b0;
			boot_q <= 1'b1;
		end else begin
			fmt_q <= fmt_d;
			ctrl_q <= ctrl_d;
			pout_q <= pout_d;
			ack_q <= ack_d;
			boot_q <= boot_d;
		end
	end

	// ----------------------------------------------------------------
	// Bit timing; rate chosen by the control port
	// ----------------------------------------------------------------
	localparam logic [17:0] CYC_LO = 18'(CLK_HZ / `SPIO_BAUD_LO);
	localparam logic [17:0] CYC_HI = 18'(CLK_HZ / `SPIO_BAUD_HI);
	logic [17:0] bit_cyc;
	logic [3:0] nbits;
	always_comb begin
		bit_cyc = ctrl_q[`SPIO_CT_RATE] ? CYC_HI : CYC_LO;
		nbits = 4'd5 + {2'b00, fmt_q[1:0]};
	end

	// ----------------------------------------------------------------
	// Transmitter fed from the FIFO
	// ----------------------------------------------------------------
	logic f_valid, f_ready, f_in_ready;
	logic [7:0] f_data;
	spio_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(wr_fc),
		.in_data(io_req.wdata),
		.in_ready(f_in_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_ready)
	);
	spio_st_t tst_q, tst_d;
	logic [17:0] tcnt_q, tcnt_d;
	logic [3:0] tidx_q, tidx_d;
	logic [7:0] tsh_q, tsh_d;
	logic tpar_q, tpar_d, tline_q, tline_d;
	always_comb begin
		tst_d = tst_q;
		tcnt_d = tcnt_q;
		tidx_d = tidx_q;
		tsh_d = tsh_q;
		tpar_d = tpar_q;
		tline_d = tline_q;
		f_ready = 1'b0;
		if (tst_q != SPIO_IDLE && tcnt_q != 18'd0) begin
			tcnt_d = tcnt_q - 18'd1;
		end else begin
			tcnt_d = bit_cyc - 18'd1;
			unique case (tst_q)
			SPIO_IDLE: begin
				tline_d = 1'b1;
				if (f_valid) begin
					f_ready = 1'b1;
					tsh_d = f_data;
					tpar_d = fmt_q[`SPIO_CF_PAR_ODD_N];
					tidx_d = 4'd0;
					tline_d = 1'b0;
					tst_d = SPIO_DATA;
				end
			end
			SPIO_DATA: begin
				tline_d = tsh_q[0];
				tpar_d = tpar_q ^ tsh_q[0];
				tsh_d = {1'b0, tsh_q[7:1]};
				tidx_d = tidx_q + 4'd1;
				if (tidx_q + 4'd1 == nbits) begin
					tst_d = fmt_q[`SPIO_CF_NO_PARITY] ? SPIO_STOP : SPIO_PAR;
					tidx_d = 4'd0;
				end
			end
			SPIO_PAR: begin
				tline_d = tpar_q;
				tst_d = SPIO_STOP;
				tidx_d = 4'd0;
			end
			SPIO_STOP: begin
				// Leave only once every stop bit has run its full length.
				tline_d = 1'b1;
				tidx_d = tidx_q + 4'd1;
				if (tidx_q == (fmt_q[`SPIO_CF_STOP2] ? 4'd2 : 4'd1)) begin
					tst_d = SPIO_IDLE;
				end
			end
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tst_q <= SPIO_IDLE;
			tcnt_q <= 18'd0;
			tidx_q <= 4'd0;
			tsh_q <= 8'h00;
			tpar_q <= 1'b0;
			tline_q <= 1'b1;
		end else begin
			tst_q <= tst_d;
			tcnt_q <= tcnt_d;
			tidx_q <= tidx_d;
			tsh_q <= tsh_d;
			tpar_q <= tpar_d;
			tline_q <= tline_d;
		end
	end

	// ----------------------------------------------------------------
	// Receiver; line chosen by the route bit
	// ----------------------------------------------------------------
	spio_st_t rst_q, rst_d;
	logic [17:0] rcnt_q, rcnt_d;
	logic [3:0] ridx_q, ridx_d;
	logic [7:0] rsh_q, rsh_d, rbuf_q, rbuf_d;
	logic rpar_q, rpar_d, rav_q, rav_d, ovr_q, ovr_d;
	logic fe_q, fe_d, pe_q, pe_d, rxl;
	always_comb begin
		// serial only while bit 7 set
		rxl = ctrl_q[`SPIO_CT_SERIAL_SEL] ? srx_q[1] : crx_q[1];
		rst_d = rst_q;
		rcnt_d = rcnt_q;
		ridx_d = ridx_q;
		rsh_d = rsh_q;
		rpar_d = rpar_q;
		rbuf_d = rbuf_q;
		rav_d = rav_q && !rd_fc;
		ovr_d = ovr_q;
		fe_d = fe_q;
		pe_d = pe_q;
		if (rst_q == SPIO_IDLE) begin
			if (!rxl) begin
				rcnt_d = {1'b0, bit_cyc[17:1]};
				rst_d = SPIO_DATA;
				ridx_d = 4'hF;
				rpar_d = fmt_q[`SPIO_CF_PAR_ODD_N];
			end
		end else if (rcnt_q != 18'd0) begin
			rcnt_d = rcnt_q - 18'd1;
		end else begin
			rcnt_d = bit_cyc - 18'd1;
			unique case (rst_q)
			SPIO_DATA: begin
				if (ridx_q == 4'hF) begin
					ridx_d = 4'd0;
					rsh_d = 8'h00;
					if (rxl) begin
						rst_d = SPIO_IDLE;
					end
				end else begin
					rsh_d = rsh_q | ({7'h00, rxl} << ridx_q[2:0]);
					rpar_d = rpar_q ^ rxl;
					ridx_d = ridx_q + 4'd1;
					if (ridx_q + 4'd1 == nbits) begin
						rst_d = fmt_q[`SPIO_CF_NO_PARITY] ? SPIO_STOP : SPIO_PAR;
					end
				end
			end
			SPIO_PAR: begin
				rpar_d = rpar_q ^ rxl;
				rst_d = SPIO_STOP;
			end
			SPIO_STOP: begin
				// frame done: available flag set wins over read, error flags reload
				rst_d = SPIO_IDLE;
				rbuf_d = rsh_q;
				rav_d = 1'b1;
				ovr_d = rav_q && !rd_fc;
				fe_d = !rxl;
				pe_d = !fmt_q[`SPIO_CF_NO_PARITY] && rpar_q;
			end
			default: rst_d = SPIO_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= SPIO_IDLE;
			rcnt_q <= 18'd0;
			ridx_q <= 4'd0;
			rsh_q <= 8'h00;
			rpar_q <= 1'b0;
			rbuf_q <= 8'h00;
			rav_q <= 1'b0;
			ovr_q <= 1'b0;
			fe_q <= 1'b0;
			pe_q <= 1'b0;
		end else begin
			rst_q <= rst_d;
			rcnt_q <= rcnt_d;
			ridx_q <= ridx_d;
			rsh_q <= rsh_d;
			rpar_q <= rpar_d;
			rbuf_q <= rbuf_d;
			rav_q <= rav_d;
			ovr_q <= ovr_d;
			fe_q <= fe_d;
			pe_q <= pe_d;
		end
	end

	// ----------------------------------------------------------------
	// Read mux and registered outputs
	// ----------------------------------------------------------------
	logic [7:0] rdata_d;
	logic tx_empty;
	always_comb begin
		tx_empty = !f_valid && tst_q == SPIO_IDLE;
		unique case (io_req.addr)
		`SPIO_SERIAL_DATA_PORT: rdata_d = rbuf_q;
		`SPIO_SERIAL_STATUS_CONFIG:
			rdata_d = {3'b000, pe_q, fe_q, ovr_q, rav_q, tx_empty};
		`SPIO_CONTROL_HANDSHAKE_PORT: rdata_d = {ack_q, pav_q[1], 6'h00};
		`SPIO_PARALLEL_DATA_PORT: rdata_d = pin2_q;
		default: rdata_d = 8'h00;
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata <= 8'h00;
			rom_sel <= 1'b0;
			rom_addr <= 16'h0000;
			serial_tx <= 1'b1;
			cass_tx <= 1'b1;
			motor1_on <= 1'b0;
			motor2_on <= 1'b0;
			par_out <= 8'h00;
			par_ack <= 1'b0;
		end else begin
			io_rdata <= rdata_d;
			rom_sel <= mem_addr[15:13] == 3'b111 ||
				(boot_d && mem_addr[15:13] == 3'b000);
			rom_addr <= {3'b000, mem_addr[12:0]} | `SPIO_ROM_BASE;
			serial_tx <= ctrl_q[`SPIO_CT_SERIAL_SEL] ? tline_q : 1'b1;
			cass_tx <= ctrl_q[`SPIO_CT_SERIAL_SEL] ? 1'b1 : tline_q;
			motor1_on <= ctrl_q[`SPIO_CT_MOTOR1];
			motor2_on <= ctrl_q[`SPIO_CT_MOTOR2];
			par_out <= pout_q;
			par_ack <= ack_q;
		end
	end
endmodule

// ===== spio_peer.sv
// Far-end model: parallel peripheral and looped-back serial and tape lines.
`timescale 1ns/10ps
module spio_peer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Bench commands
	input wire logic offer,
	input wire logic [7:0] offer_byte,
	// Port lines
	input wire logic par_ack,
	input wire logic serial_tx,
	input wire logic cass_tx,
	input wire logic motor1_on,
	input wire logic motor2_on,
	output logic [7:0] par_in,
	output logic par_avail,
	output logic serial_rx,
	output logic cass_rx
);
	// The terminal echoes each frame; tape moves only while a motor runs.
	assign serial_rx = serial_tx;
	assign cass_rx = (motor1_on || motor2_on) ? cass_tx : 1'b1;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			par_in <= 8'h00;
			par_avail <= 1'b0;
		end else if (offer) begin
			par_in <= offer_byte;
			par_avail <= 1'b1;
		end else if (par_ack) begin
			par_avail <= 1'b0;
		end
	end
endmodule

// ===== spio_ports_sva.sv
// Port-level checker for the I/O port block.
`timescale 1ns/10ps
module spio_ports_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Processor side
	input wire spio_pkg::spio_io_req_t io_req,
	input wire logic [7:0] io_rdata,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic rom_sel,
	input wire logic [15:0] rom_addr,
	// Device side
	input wire logic serial_tx,
	input wire logic cass_tx,
	input wire logic motor1_on,
	input wire logic motor2_on,
	input wire logic [7:0] par_out,
	input wire logic par_ack
);
	import spio_pkg::*;
	logic fe_wr;
	logic ff_wr;
	logic [7:0] wdata;
	logic boot_q;
	logic boot_d;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	assign fe_wr = io_req.wr && io_req.addr == 8'hFE;
	assign ff_wr = io_req.wr && io_req.addr == 8'hFF;
	assign wdata = io_req.wdata;
	// The boot map ends at the first read of the top ROM region.
	always_comb begin
		boot_d = boot_q && !(mem_rd && mem_addr[15:13] == 3'h7);
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= boot_d;
		end
	end
	motor_write_a: assert property (
		fe_wr |-> ##2
		{2'h0, motor2_on, motor1_on, 4'h0} == ($past(wdata, 2) & 8'h30)
	) else $error("motor levels differ from control write");
	ack_write_a: assert property (
		fe_wr |-> ##2 {par_ack, 7'h00} == ($past(wdata, 2) & 8'h80)
	) else $error("acknowledge differs from control write");
	par_write_a: assert property (
		ff_wr |-> ##2 par_out == $past(wdata, 2)
	) else $error("parallel output differs from write");
	ctl_hold_a: assert property (
		!$past(fe_wr, 2) |-> $stable({par_ack, motor2_on, motor1_on})
	) else $error("control outputs moved without a write");
	par_hold_a: assert property (
		!$past(ff_wr, 2) |-> $stable(par_out)
	) else $error("parallel output moved without a write");
	unmapped_read_a: assert property (
		io_req.addr < 8'hFC |=> io_rdata == 8'h00
	) else $error("unmapped port read not zero");
	serial_idle_a: assert property (
		!par_ack && !$past(par_ack) |-> serial_tx
	) else $error("serial line active while routed to tape");
	boot_low_a: assert property (
		mem_rd && boot_q && mem_addr[15:13] == 3'h0 |=> rom_sel &&
		rom_addr == (16'hE000 | ($past(mem_addr) & 16'h1FFF))
	) else $error("boot read not mapped to monitor ROM");
	boot_off_a: assert property (
		mem_rd && !boot_q && mem_addr[15:13] != 3'h7 |=> !rom_sel
	) else $error("low read still mapped after boot");
endmodule

bind spio_ports spio_ports_chk i_chk (.clk_sys(clk_sys), .arst_n(arst_n),
	.io_req(io_req), .io_rdata(io_rdata), .mem_rd(mem_rd),
	.mem_addr(mem_addr), .rom_sel(rom_sel), .rom_addr(rom_addr),
	.serial_tx(serial_tx), .cass_tx(cass_tx), .motor1_on(motor1_on),
	.motor2_on(motor2_on), .par_out(par_out), .par_ack(par_ack));

// ===== test_serial_parallel_io_ports.sv
// Self-checking bench for the I/O port block.
`timescale 1ns/10ps
`include "spio_regs.svh"
module test_serial_parallel_io_ports;
	import spio_pkg::*;
	// A low clock figure keeps bit times short enough to run every frame.
	localparam int BENCH_HZ = 9600;
	int n = 0;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	spio_io_req_t io_req = '0;
	logic mem_rd = 1'b0;
	logic [15:0] mem_addr = 16'h0000;
	logic offer = 1'b0;
	logic [7:0] offer_byte = 8'h00;
	logic [7:0] io_rdata, par_in, par_out, b;
	logic [15:0] rom_addr;
	logic rom_sel, serial_rx, cass_rx, serial_tx, cass_tx;
	logic motor1_on, motor2_on, par_avail, par_ack;
	logic [31:0] seed = 32'h542A;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;

	always #10 clk_sys = ~clk_sys;

	spio_ports #(.CLK_HZ(BENCH_HZ)) i_dut (.clk_sys(clk_sys),
		.arst_n(arst_n), .io_req(io_req),
		.io_rdata(io_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.rom_sel(rom_sel), .rom_addr(rom_addr), .serial_rx(serial_rx),
		.cass_rx(cass_rx), .serial_tx(serial_tx), .cass_tx(cass_tx),
		.motor1_on(motor1_on), .motor2_on(motor2_on), .par_in(par_in),
		.par_avail(par_avail), .par_out(par_out), .par_ack(par_ack));
	spio_peer i_peer (.clk_sys(clk_sys), .arst_n(arst_n), .offer(offer),
		.offer_byte(offer_byte), .par_ack(par_ack), .serial_tx(serial_tx),
		.cass_tx(cass_tx), .motor1_on(motor1_on), .motor2_on(motor2_on),
		.par_in(par_in), .par_avail(par_avail), .serial_rx(serial_rx),
		.cass_rx(cass_rx));

	function automatic void step();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
	endfunction
	function automatic logic [2:0] ctl_exp(input logic [7:0] v);
		return {v[7], v[5], v[4]};
	endfunction
	function automatic logic [7:0] len_mask(input logic [1:0] len);
		return 8'hFF >> (2'd3 - len);
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic io(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_sys);
		io_req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk_sys);
		io_req.wr <= 1'b0;
		io_req.rd <= 1'b0;
		#1;
	endtask
	task automatic poll(input int pos);
		io(8'hFD, 8'h00, 1'b0);
		for (int k = 0; k < 400 && !io_rdata[pos]; k++) begin
			io(8'hFD, 8'h00, 1'b0);
		end
	endtask
	task automatic xfer(input logic [7:0] v, input logic [1:0] len);
		io(8'hFC, v, 1'b1);
		poll(1);
		check(io_rdata[4:1], 4'h1);
		io(8'hFC, 8'h00, 1'b0);
		check(io_rdata, v & len_mask(len));
		poll(0);
		check(io_rdata[4:0], 5'h01);
	endtask
	task automatic mem(input logic [15:0] a);
		@(posedge clk_sys);
		mem_rd <= 1'b1;
		mem_addr <= a;
		@(posedge clk_sys);
		mem_rd <= 1'b0;
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// A hang costs one mismatch and ends the run.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 70000) begin
			errors++;
			end_of_test();
		end
	end

	initial begin
		repeat (4) @(posedge clk_sys);
		check({serial_tx, cass_tx, motor1_on, motor2_on, par_ack, par_out},
			13'h1800);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		mem(16'h0123);
		check({rom_sel, rom_addr}, 17'h1E123);
		mem(16'hE456);
		check(rom_sel, 1'b1);
		mem(16'h0123);
		check(rom_sel, 1'b0);
		io(8'hFD, 8'h00, 1'b0);
		check(io_rdata[4:0], 5'h01);
		io(8'hFE, 8'h50, 1'b1);
		io(8'hFD, 8'h13, 1'b1);
		io(8'hFC, 8'hA5, 1'b1);
		io(8'hFD, 8'h00, 1'b0);
		check(io_rdata[0], 1'b0);
		check({cass_tx, serial_tx, motor1_on}, 3'h3);
		// The start bit of the first frame lasts one bit time.
		while (!cass_tx && n < 1000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check(24'(n), 24'(BENCH_HZ / `SPIO_BAUD_HI));
		poll(1);
		check(io_rdata[4:1], 4'h1);
		io(8'hFC, 8'h00, 1'b0);
		check(io_rdata, 8'hA5);
		poll(0);
		// leader of zeros and a one
		for (int i = 0; i < 101; i++) begin
			xfer((i == 100) ? 8'h01 : 8'h00, 2'b11);
		end
		// motors off after the tape transfer
		io(8'hFE, 8'h00, 1'b1);
		io(8'hFE, 8'h80, 1'b1);
		check({motor2_on, motor1_on}, 2'b00);
		for (int i = 0; i < 6; i++) begin
			step();
			b = (i == 0) ? 8'h0F : (i == 1) ? 8'h10 : {3'b000, seed[4:0]};
			io(8'hFD, b, 1'b1);
			xfer(seed[15:8], b[1:0]);
		end
		for (int i = 0; i < 40; i++) begin
			step();
			b = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
			io(8'hFE, b, 1'b1);
			io(8'hFF, seed[15:8], 1'b1);
			@(posedge clk_sys);
			offer <= 1'b1;
			offer_byte <= seed[31:24];
			@(posedge clk_sys);
			offer <= 1'b0;
			#1;
			check(par_out, seed[15:8]);
			repeat (4) @(posedge clk_sys);
			io(8'hFF, 8'h00, 1'b0);
			check(io_rdata, seed[31:24]);
			io(8'hFE, 8'h00, 1'b0);
			check(io_rdata[7:6], {b[7], !b[7]});
			io({1'b0, seed[22:16]}, 8'h00, 1'b0);
			check(io_rdata, 8'h00);
			check({par_ack, motor2_on, motor1_on}, ctl_exp(b));
		end
		end_of_test();
	end
endmodule
